// file: src/pasr_read.v
`timescale 1ns/10ps
`default_nettype none

`include "pasr_regs.vh"

// Overview of operation
// - Group 0 peek returns best pending id
// - Group 1 peek returns best pending id
// - 32-bit word, id in 23:0, top zero
// - Unobservable pending gives special id 1020/1021/1023
// - Id width 16 or 24, upper bits zero
// - Acknowledge read returns id and acknowledges
// - Acknowledge only if signalable and acknowledgeable
// - Non-secure EL1 routed reads go virtual
// - Interface disabled: EL1 reads trap EL1
// - Hypervisor trap-all bits trap to EL2
// - Secure EL1 reads trap EL3 when routed
// - EL2 reads trap EL3 when routed
// - Non-secure EL1 traps EL3 unless hyp-routed
// - Read-only, no EL0, fixed encodings
// - Completion id matches latest valid acknowledge
// - Split mode: completion drops priority only
module pasr_read
(
    input wire mclk,
    input wire resetn,
    input wire rd_req,
    input wire rd_write,
    input wire [1:0] rd_op0,
    input wire [2:0] rd_op1,
    input wire [3:0] rd_crn,
    input wire [3:0] rd_crm,
    input wire [2:0] rd_op2,
    input wire [1:0] cur_el,
    input wire cur_secure,
    input wire sysreg_interface_enable,
    input wire hyp_trap_all_group0,
    input wire hyp_trap_all_group1,
    input wire hyp_fast_int_routing,
    input wire hyp_normal_int_routing,
    input wire el3_fast_int_routing,
    input wire el3_normal_int_routing,
    input wire identifier_width_field,
    input wire split_completion_mode,
    input wire grp0_pend_valid,
    input wire [23:0] grp0_pend_id,
    input wire grp0_pend_secure_only,
    input wire grp0_pend_signalable,
    input wire grp1_pend_valid,
    input wire [23:0] grp1_pend_id,
    input wire grp1_pend_other_state,
    input wire grp1_pend_other_secure,
    input wire grp1_pend_signalable,
    input wire cmpl_req,
    input wire cmpl_group,
    input wire [23:0] cmpl_id,
    output reg rd_ack,
    output reg [31:0] rd_data,
    output reg [2:0] rd_resp,
    output reg ack_pulse,
    output reg ack_group,
    output reg [23:0] ack_id,
    output reg drop_pulse,
    output reg deact_pulse,
    output reg [23:0] drop_id,
    output reg cmpl_mismatch
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function enc_match;
        input [3:0] crm;
        input [2:0] op2;
        begin
            enc_match = (rd_op0 == `PASR_OP0) && (rd_op1 == `PASR_OP1) &&
                (rd_crn == `PASR_CRN) && (rd_crm == crm) && (rd_op2 == op2);
        end
    endfunction

    // Group 1 takes the second control bit, group 0 the first
    function grp_pick;
        input sel1;
        input bit0;
        input bit1;
        begin
            grp_pick = sel1 ? bit1 : bit0;
        end
    endfunction

    // One tracking slot per group and security state pair
    function [1:0] slot_of;
        input grp;
        input sec;
        begin
            slot_of = {grp, sec};
        end
    endfunction

    wire hit_peek0 = enc_match(`PASR_CRM_GRP0, `PASR_OP2_PEEK);
    wire hit_peek1 = enc_match(`PASR_CRM_GRP1, `PASR_OP2_PEEK);
    wire hit_ack0 = enc_match(`PASR_CRM_GRP0, `PASR_OP2_ACK);
    wire hit_ack1 = enc_match(`PASR_CRM_GRP1, `PASR_OP2_ACK);
    // Any other encoding is answered as unmapped, never as a read
    wire hit_any = hit_peek0 | hit_peek1 | hit_ack0 | hit_ack1;
    wire grp1 = hit_peek1 | hit_ack1;
    wire is_ack = hit_ack0 | hit_ack1;

    wire at_el1 = (cur_el == `PASR_EL1);
    wire ns_el1 = at_el1 & ~cur_secure;
    wire hyp_route = grp_pick(grp1, hyp_fast_int_routing, hyp_normal_int_routing);
    wire el3_route = grp_pick(grp1, el3_fast_int_routing, el3_normal_int_routing);
    wire trap_all = grp_pick(grp1, hyp_trap_all_group0, hyp_trap_all_group1);

    // Each trap source on its own; the order of checks is fixed below
    wire refuse = rd_write | (cur_el == `PASR_EL0);
    wire trap_el1 = at_el1 & ~sysreg_interface_enable;
    wire go_virtual = ns_el1 & hyp_route;
    wire trap_el2 = ns_el1 & trap_all;
    wire trap_el3_s = at_el1 & cur_secure & el3_route;
    wire trap_el3_h = (cur_el == `PASR_EL2) & el3_route;
    wire trap_el3_n = ns_el1 & el3_route & ~hyp_route;
    // Refusal outranks every trap; virtual redirect outranks EL2 and EL3

    // ----------------------------------------------------------------
    // Trap and redirection priority
    // ----------------------------------------------------------------
    reg [2:0] resp;
    always @*
    begin
        resp = `PASR_RESP_OK;
        if (!hit_any)
            resp = `PASR_RESP_UNMAPPED;
        else if (refuse)
            resp = `PASR_RESP_UNDEF;
        else if (trap_el1)
            resp = `PASR_RESP_TRAP_EL1;
        else if (go_virtual)
            resp = `PASR_RESP_VIRTUAL;
        else if (trap_el2)
            resp = `PASR_RESP_TRAP_EL2;
        else if (trap_el3_s)
            resp = `PASR_RESP_TRAP_EL3;
        else if (trap_el3_h)
            resp = `PASR_RESP_TRAP_EL3;
        else if (trap_el3_n)
            resp = `PASR_RESP_TRAP_EL3;
    end

    // ----------------------------------------------------------------
    // Observability and special identifiers
    // ----------------------------------------------------------------
    // Secure-only group 0 ids are secure-owned; non-secure code sees them only from EL3.
    // Peeks ignore priority; only an acknowledge needs a signalable id.
    reg [23:0] id_sel;
    reg valid_sel;
    always @*
    begin
        id_sel = `PASR_SPECIAL_NONE;
        valid_sel = 1'b0;
        if (!grp1)
        begin
            if (grp0_pend_valid && (!is_ack || grp0_pend_signalable))
            begin
                if (grp0_pend_secure_only && !cur_secure && cur_el != `PASR_EL3)
                    id_sel = `PASR_SPECIAL_NONE;
                else
                begin
                    id_sel = grp0_pend_id;
                    valid_sel = 1'b1;
                end
            end
        end
        else if (grp1_pend_valid && (!is_ack || grp1_pend_signalable))
        begin
            if (grp1_pend_other_state && cur_el == `PASR_EL3)
                id_sel = grp1_pend_other_secure ? `PASR_SPECIAL_SECURE
                    : `PASR_SPECIAL_NONSECURE;
            else if (grp1_pend_other_state)
                id_sel = `PASR_SPECIAL_NONE;
            else
            begin
                id_sel = grp1_pend_id;
                valid_sel = 1'b1;
            end
        end
        // Width zeroing touches real ids only; specials fit in 16 bits
        if (valid_sel && !identifier_width_field)
            id_sel[`PASR_ID_MSB:`PASR_ID16_MSB+1] = 8'h00;
    end

    wire read_ok = rd_req & (resp == `PASR_RESP_OK);
    // Special ids are never recorded, so they cannot be completed
    wire do_ack = read_ok & is_ack & valid_sel;

    // ----------------------------------------------------------------
    // Acknowledged-id tracking per group and security state
    // ----------------------------------------------------------------
    localparam SLOTS = 4;
    reg [23:0] last_id [0:SLOTS-1];
    reg last_live [0:SLOTS-1];
    // A newer acknowledge in a slot overwrites the older live id
    wire [1:0] wr_slot = slot_of(grp1, cur_secure);
    // Completion is matched in the caller's present security state
    wire [1:0] cm_slot = slot_of(cmpl_group, cur_secure);
    wire cmpl_ok = last_live[cm_slot] && (last_id[cm_slot] == cmpl_id);

    genvar s;
    generate
        for (s = 0; s < SLOTS; s = s + 1)
        begin : g_slot
            // Acknowledge and completion on one slot together: acknowledge wins
            always @(posedge mclk or negedge resetn)
            begin
                if (!resetn)
                begin
                    last_id[s] <= `PASR_ID_RESET;
                    last_live[s] <= 1'b0;
                end
                else if (do_ack && wr_slot == s)
                begin
                    last_id[s] <= id_sel;
                    last_live[s] <= 1'b1;
                end
                else if (cmpl_req && cmpl_ok && cm_slot == s)
                    last_live[s] <= 1'b0;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read answer
    // ----------------------------------------------------------------
    // Data is zero on any refused read, so no stale id leaks out.
    // Response reads OK between answers.
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_ack <= 1'b0;
            rd_data <= `PASR_DATA_RESET;
            rd_resp <= `PASR_RESP_OK;
        end
        else
        begin
            rd_ack <= rd_req;
            rd_resp <= rd_req ? resp : `PASR_RESP_OK;
            rd_data <= read_ok ? {8'h00, id_sel} : `PASR_DATA_RESET;
        end
    end

    // ----------------------------------------------------------------
    // Acknowledge record
    // ----------------------------------------------------------------
    // Group and id hold until the next acknowledge.
    // Special ids give no pulse, so the pending source stays set.
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_pulse <= 1'b0;
            ack_group <= 1'b0;
            ack_id <= `PASR_ID_RESET;
        end
        else
        begin
            ack_pulse <= do_ack;
            if (do_ack)
            begin
                ack_group <= grp1;
                ack_id <= id_sel;
            end
        end
    end

    // ----------------------------------------------------------------
    // Completion
    // ----------------------------------------------------------------
    // Drop id is kept even on a mismatch.
    // Split mode leaves deactivation to a later, separate write.
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            drop_pulse <= 1'b0;
            deact_pulse <= 1'b0;
            drop_id <= `PASR_ID_RESET;
            cmpl_mismatch <= 1'b0;
        end
        else
        begin
            drop_pulse <= cmpl_req & cmpl_ok;
            deact_pulse <= cmpl_req & cmpl_ok & ~split_completion_mode;
            if (cmpl_req)
                drop_id <= cmpl_id;
            cmpl_mismatch <= cmpl_req & ~cmpl_ok;
        end
    end

endmodule

`default_nettype wire

// file: src/pasr_regs.vh
`ifndef PASR_REGS_VH
`define PASR_REGS_VH

// ----------------------------------------------------------------
// System register encodings (op0, op1, CRn, CRm, op2)
// ----------------------------------------------------------------
`define PASR_OP0 2'h3
`define PASR_OP1 3'h0
`define PASR_CRN 4'hC
`define PASR_CRM_GRP0 4'h8
`define PASR_CRM_GRP1 4'hC
`define PASR_OP2_PEEK 3'h2
`define PASR_OP2_ACK 3'h0

// ----------------------------------------------------------------
// Field layout and special identifiers
// ----------------------------------------------------------------
`define PASR_ID_MSB 23
`define PASR_ID16_MSB 15
`define PASR_SPECIAL_SECURE 24'h0003FC
`define PASR_SPECIAL_NONSECURE 24'h0003FD
`define PASR_SPECIAL_NONE 24'h0003FF
`define PASR_DATA_RESET 32'h00000000
`define PASR_ID_RESET 24'h000000

// ----------------------------------------------------------------
// Exception levels and answer codes
// ----------------------------------------------------------------
`define PASR_EL0 2'h0
`define PASR_EL1 2'h1
`define PASR_EL2 2'h2
`define PASR_EL3 2'h3
`define PASR_RESP_OK 3'h0
`define PASR_RESP_UNDEF 3'h1
`define PASR_RESP_TRAP_EL1 3'h2
`define PASR_RESP_TRAP_EL2 3'h3
`define PASR_RESP_TRAP_EL3 3'h4
`define PASR_RESP_VIRTUAL 3'h5
`define PASR_RESP_UNMAPPED 3'h6

`endif

// file: verification/pasr_read_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pasr_read_chk
(
    input wire mclk,
    input wire resetn,
    input wire rd_req,
    input wire rd_write,
    input wire [1:0] rd_op0,
    input wire [2:0] rd_op1,
    input wire [3:0] rd_crn,
    input wire [3:0] rd_crm,
    input wire [2:0] rd_op2,
    input wire [1:0] cur_el,
    input wire cur_secure,
    input wire sysreg_interface_enable,
    input wire hyp_fast_int_routing,
    input wire el3_fast_int_routing,
    input wire el3_normal_int_routing,
    input wire identifier_width_field,
    input wire rd_ack,
    input wire [31:0] rd_data,
    input wire [2:0] rd_resp,
    input wire ack_pulse
);
wire g0 = rd_crm == 4'h8;
wire hit = rd_op0 == 2'h3 && rd_op1 == 3'h0 && rd_crn == 4'hC && (g0 || rd_crm == 4'hC)
    && (rd_op2 == 3'h0 || rd_op2 == 3'h2);
default clocking @(posedge mclk); endclocking
default disable iff (!resetn);
// ----------------------------------------
// Read answers and routing
// ----------------------------------------
sequence s_rd;
    rd_req && hit && !rd_write;
endsequence
ans_next_a: assert property (rd_req |=> rd_ack)
    else $error("no answer");
top_zero_a: assert property (rd_ack |-> rd_data[31:24] == 8'h00)
    else $error("top bits set");
narrow_id_a: assert property (rd_ack && !$past(identifier_width_field)
    |-> rd_data[23:16] == 8'h00)
    else $error("narrow id wide");
el0_undef_a: assert property (rd_req && hit && cur_el == 2'h0 |=> rd_resp == 3'h1)
    else $error("el0 allowed");
off_trap_a: assert property (s_rd ##0 (cur_el == 2'h1 && !sysreg_interface_enable)
    |=> rd_resp == 3'h2)
    else $error("no el1 trap");
virt_redir_a: assert property (s_rd ##0 (cur_el == 2'h1 && !cur_secure
    && sysreg_interface_enable && g0 && hyp_fast_int_routing) |=> rd_resp == 3'h5)
    else $error("no redirect");
el2_route_a: assert property (s_rd ##0 (cur_el == 2'h2
    && (g0 ? el3_fast_int_routing : el3_normal_int_routing)) |=> rd_resp == 3'h4)
    else $error("no el3 trap");
peek_quiet_a: assert property (rd_ack && $past(rd_op2) == 3'h2 |-> !ack_pulse)
    else $error("peek acked");
endmodule
`default_nettype wire

// file: verification/pasr_pend_model.sv
`timescale 1ns/10ps
`default_nettype none
module pasr_pend_model
(
    input wire mclk,
    input wire resetn,
    input wire set0,
    input wire set1,
    input wire [23:0] set_id,
    input wire ack_pulse,
    input wire ack_group,
    output logic p0_valid,
    output logic [23:0] p0_id,
    output logic p1_valid,
    output logic [23:0] p1_id
);
// ----------------------------------------
// Pending source, cleared only by acknowledge
// ----------------------------------------
always @(posedge mclk or negedge resetn)
begin
    if (!resetn)
        {p0_valid, p0_id, p1_valid, p1_id} <= 50'h0;
    else
    begin
        if (set0 || (ack_pulse && !ack_group))
            {p0_valid, p0_id} <= {set0, set0 ? set_id : p0_id};
        if (set1 || (ack_pulse && ack_group))
            {p1_valid, p1_id} <= {set1, set1 ? set_id : p1_id};
    end
end
endmodule
`default_nettype wire

// file: verification/pasr_read_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pasr_read_bench;
reg mclk = 1'b0, resetn = 1'b0, rd_req = 1'b0, wr = 1'b0, sec = 1'b1, sig = 1'b1, so = 1'b0;
reg split = 1'b0, cg = 1'b0, creq = 1'b0, set0 = 1'b0, set1 = 1'b0, got_ack;
reg [1:0] el = 2'h1;
reg [1:0] op0 = 2'h3;
reg os = 1'b0, osec = 1'b0;
reg [3:0] crm = 4'h8;
reg [2:0] op2 = 3'h2;
reg [7:0] ctl = 8'h81;
reg [23:0] cid = 24'h0, set_id = 24'h0;
wire rd_ack, ack_pulse, ack_group, drop, deact, mis, p0v, p1v;
wire [31:0] rd_data;
wire [2:0] rd_resp;
wire [23:0] p0id, p1id, aid, did;
integer fail_count = 0, n_tests = 0;
always #4 mclk = ~mclk;
pasr_read dut (.mclk(mclk), .resetn(resetn), .rd_req(rd_req), .rd_write(wr), .rd_op0(op0),
    .rd_op1(3'h0), .rd_crn(4'hC), .rd_crm(crm), .rd_op2(op2), .cur_el(el), .cur_secure(sec),
    .sysreg_interface_enable(ctl[0]), .hyp_trap_all_group0(ctl[1]), .hyp_trap_all_group1(ctl[2]),
    .hyp_fast_int_routing(ctl[3]), .hyp_normal_int_routing(ctl[4]), .el3_fast_int_routing(ctl[5]),
    .el3_normal_int_routing(ctl[6]), .identifier_width_field(ctl[7]), .split_completion_mode(split),
    .grp0_pend_valid(p0v), .grp0_pend_id(p0id), .grp0_pend_secure_only(so),
    .grp0_pend_signalable(sig), .grp1_pend_valid(p1v), .grp1_pend_id(p1id),
    .grp1_pend_other_state(os), .grp1_pend_other_secure(osec), .grp1_pend_signalable(sig),
    .cmpl_req(creq), .cmpl_group(cg), .cmpl_id(cid), .rd_ack(rd_ack), .rd_data(rd_data),
    .rd_resp(rd_resp), .ack_pulse(ack_pulse), .ack_group(ack_group), .ack_id(aid),
    .drop_pulse(drop), .deact_pulse(deact), .drop_id(did), .cmpl_mismatch(mis));
pasr_pend_model far (.mclk(mclk), .resetn(resetn), .set0(set0), .set1(set1), .set_id(set_id),
    .ack_pulse(ack_pulse), .ack_group(ack_group), .p0_valid(p0v), .p0_id(p0id), .p1_valid(p1v),
    .p1_id(p1id));
task close_out;
begin
    if (fail_count == 0 && n_tests > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
end
endtask
task chk(input [35:0] got, input [35:0] want);
begin
    n_tests = n_tests + 1;
    if (got !== want)
    begin
        fail_count = fail_count + 1;
        $display("[ERR] %0t got %h want %h", $time, got, want);
    end
end
endtask
// ----------------------------------------
// One request per call, answer a cycle on
// ----------------------------------------
task rd(input [7:0] c, input [1:0] e, input s, input w, input [3:0] m, input [2:0] o,
    input [34:0] x);
begin
    @(negedge mclk);
    {ctl, el, sec, wr, crm, op2, rd_req} = {c, e, s, w, m, o, 1'b1};
    @(negedge mclk);
    rd_req = 1'b0;
    got_ack = ack_pulse;
    chk({rd_ack, rd_resp, rd_data}, {1'b1, x});
end
endtask
task cm(input s, input g, input [23:0] i, input [2:0] x, input [2:0] k);
begin
    @(negedge mclk);
    {split, cg, cid, creq} = {s, g, i, 1'b1};
    @(negedge mclk);
    creq = 1'b0;
    chk({33'h0, {drop, deact, mis} & k}, {33'h0, x});
end
endtask
initial
begin
    #20000;
    fail_count = fail_count + 1;
    close_out;
end
initial
begin
    repeat (5) @(posedge mclk);
    @(negedge mclk) resetn = 1'b1;
    {set_id, set0} = {24'h000123, 1'b1};
    @(negedge mclk) {set_id, set0, set1} = {24'h1A5A5A, 2'b01};
    @(negedge mclk) set1 = 1'b0;
    rd(8'h81, 2'h1, 1, 0, 4'h8, 3'h2, {3'h0, 32'h123});
    chk({35'h0, got_ack}, 36'h0);
    rd(8'h81, 2'h1, 1, 0, 4'h8, 3'h2, {3'h0, 32'h123});
    so = 1'b1;
    rd(8'h81, 2'h1, 0, 0, 4'h8, 3'h2, {3'h0, 32'h3FF});
    {so, sig} = 2'b00;
    rd(8'h01, 2'h1, 1, 0, 4'hC, 3'h2, {3'h0, 32'h5A5A});
    rd(8'h81, 2'h1, 1, 0, 4'hC, 3'h0, {3'h0, 32'h3FF});
    chk({35'h0, got_ack}, 36'h0);
    sig = 1'b1;
    rd(8'h81, 2'h1, 1, 0, 4'hC, 3'h0, {3'h0, 32'h1A5A5A});
    chk({35'h0, got_ack}, 36'h1);
    chk({11'h0, ack_group, aid}, {11'h0, 1'b1, 24'h1A5A5A});
    rd(8'h81, 2'h1, 1, 0, 4'hC, 3'h2, {3'h0, 32'h3FF});
    cm(1, 1, 24'h1A5A5A, 3'h4, 3'h7);
    chk({12'h0, did}, {12'h0, 24'h1A5A5A});
    cm(1, 1, 24'h1A5A5A, 3'h1, 3'h1);
    rd(8'h81, 2'h1, 1, 0, 4'h8, 3'h0, {3'h0, 32'h123});
    cm(0, 0, 24'h000123, 3'h6, 3'h7);
    rd(8'h81, 2'h0, 1, 0, 4'h8, 3'h2, {3'h1, 32'h0});
    rd(8'h81, 2'h1, 1, 1, 4'h8, 3'h2, {3'h1, 32'h0});
    rd(8'h81, 2'h1, 1, 0, 4'h9, 3'h2, {3'h6, 32'h0});
    rd(8'h80, 2'h1, 1, 0, 4'h8, 3'h2, {3'h2, 32'h0});
    rd(8'h83, 2'h1, 0, 0, 4'h8, 3'h2, {3'h3, 32'h0});
    rd(8'h85, 2'h1, 0, 0, 4'hC, 3'h0, {3'h3, 32'h0});
    rd(8'h89, 2'h1, 0, 0, 4'h8, 3'h0, {3'h5, 32'h0});
    rd(8'h91, 2'h1, 0, 0, 4'hC, 3'h2, {3'h5, 32'h0});
    rd(8'hA1, 2'h1, 1, 0, 4'h8, 3'h2, {3'h4, 32'h0});
    rd(8'hC1, 2'h2, 0, 0, 4'hC, 3'h0, {3'h4, 32'h0});
    rd(8'hA1, 2'h1, 0, 0, 4'h8, 3'h0, {3'h4, 32'h0});
    rd(8'hA9, 2'h1, 0, 0, 4'h8, 3'h2, {3'h5, 32'h0});
    rd(8'hE1, 2'h3, 1, 0, 4'h8, 3'h2, {3'h0, 32'h3FF});
    op0 = 2'h2;
    rd(8'h81, 2'h1, 1, 0, 4'h8, 3'h2, {3'h6, 32'h0});
    op0 = 2'h3;
    @(negedge mclk) {set_id, set1} = {24'h000777, 1'b1};
    @(negedge mclk) {set1, os, osec} = 3'b011;
    rd(8'h81, 2'h3, 1, 0, 4'hC, 3'h2, {3'h0, 32'h3FC});
    osec = 1'b0;
    rd(8'h81, 2'h3, 0, 0, 4'hC, 3'h0, {3'h0, 32'h3FD});
    chk({35'h0, got_ack}, 36'h0);
    rd(8'h81, 2'h1, 1, 0, 4'hC, 3'h2, {3'h0, 32'h3FF});
    os = 1'b0;
    rd(8'h81, 2'h3, 1, 0, 4'hC, 3'h2, {3'h0, 32'h777});
    close_out;
end
endmodule
bind pasr_read pasr_read_chk chk_i (.mclk(mclk), .resetn(resetn), .rd_req(rd_req),
    .rd_write(rd_write), .rd_op0(rd_op0), .rd_op1(rd_op1), .rd_crn(rd_crn), .rd_crm(rd_crm),
    .rd_op2(rd_op2), .cur_el(cur_el), .cur_secure(cur_secure),
    .sysreg_interface_enable(sysreg_interface_enable), .hyp_fast_int_routing(hyp_fast_int_routing),
    .el3_fast_int_routing(el3_fast_int_routing), .el3_normal_int_routing(el3_normal_int_routing),
    .identifier_width_field(identifier_width_field), .rd_ack(rd_ack), .rd_data(rd_data),
    .rd_resp(rd_resp), .ack_pulse(ack_pulse));
`default_nettype wire
